// ### inc/fpr_map.svh
// Purpose: register indices, reset values, timing figures
// Assumes: byte address = 4 * register index, 32-bit apb data
// Notes:   constants only
`ifndef FPR_MAP_SVH
`define FPR_MAP_SVH

// ****************************************
// register indices (byte address is 4x)
// ****************************************
`define FPR_IDX_SPAN_RATE1  10'h05f
`define FPR_IDX_SPAN_RATE2  10'h060
`define FPR_IDX_SPAN_RATE3  10'h061
`define FPR_IDX_RAMP_CTL    10'h062
`define FPR_IDX_AUTO_CFG1   10'h063
`define FPR_IDX_AUTO_CFG2   10'h064
`define FPR_IDX_AUTO_CFG3   10'h065
`define FPR_IDX_DUTY_STAT   10'h066

// ****************************************
// reset values
// ****************************************
`define FPR_SPAN_RATE_RST   8'hcc
`define FPR_RAMP_CTL_RST    8'h00
`define FPR_AUTO_CFG_RST    16'h4000

// ****************************************
// timing: low rates in tenths of hz, high rate in hz, sweep in ms
// ****************************************
`define FPR_DUTY_STEPS      256
`define FPR_RATE_F10_0      110
`define FPR_RATE_F10_1      147
`define FPR_RATE_F10_2      221
`define FPR_RATE_F10_3      294
`define FPR_RATE_F10_4      353
`define FPR_RATE_F10_5      441
`define FPR_RATE_F10_6      588
`define FPR_RATE_F10_7      882
`define FPR_HF_HZ           25000
`define FPR_SWEEP_MS        35000
`define FPR_SWEEP_STEPS     171

`endif

// ### inc/fpr_pkg.sv
// Purpose: types shared by the fan pwm rate/span/ramp block
// Assumes: fpr_map.svh holds every number
// Notes:   types only
`default_nettype none

package fpr_pkg;

    // ****************************************
    // register and channel layouts
    // ****************************************
    typedef struct packed {
        logic [3:0] temp_span;
        logic       high_rate_select;
        logic [2:0] pwm_rate_select;
    } fpr_span_rate_s;

    typedef struct packed {
        logic [3:0] rsvd;
        logic       ramp_enable_ch1;
        logic [2:0] ramp_step_select;
    } fpr_ramp_ctl_s;

    typedef struct packed {
        logic [7:0] min_duty;
        logic [7:0] auto_start_temp;
    } fpr_auto_cfg_s;

    typedef struct packed {
        logic [23:0] step_cnt;
        logic [7:0]  phase;
    } fpr_chan_s;

endpackage

`default_nettype wire

// ### hdl/fpr_top.sv
// Purpose: span/rate config, ramped duty and pwm drive for three fans
// Assumes: apb slave, ref_clk 100 MHz, temperatures in whole deg c
// Notes:   zero-wait apb, pready always one cycle after setup
//
// What this block does
// - with lock set, writes to the three span/rate registers are ignored
// - bits 2:0 pick low rate 11.0 to 88.2 hz, code 101 is 44.1
// - after reset every channel has the high-rate bit set, so its rate code 100 (35.3 hz) is unused
// - bit 3 set drives high-frequency pwm, low-rate setting then unused
// - high-rate bit acts on fan 1, 2, 3 at 0x5f, 0x60, 0x61
// - 0x5f remote1/pwm1, 0x60 local/pwm2, 0x61 remote2/pwm3
// - bits 7:4 pick span 2 to 80 deg c for the auto slope
// - after reset every channel uses span code 1100, 32 deg c
// - each span/rate register reads 0xcc after reset
// - pwm1 duty moves gradually toward its new target
// - ramp codes 000, 001, 010 step 1, 2, 3 per time slot
// - ramping of pwm1 only while ramp enable bit 3 is one
`include "fpr_map.svh"
`default_nettype none

module fpr_top #(
    parameter int CLK_HZ        = 100_000_000,
    // sweep time over steps; longint as clk/1000 * ms overflows an int
    parameter int RAMP_SLOT_CYC = int'(longint'(CLK_HZ / 1000)
                                  * `FPR_SWEEP_MS
                                  / `FPR_SWEEP_STEPS)
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cfg_lock,
    input  wire logic [7:0]  temp_remote1,
    input  wire logic [7:0]  temp_local,
    input  wire logic [7:0]  temp_remote2,
    output logic      [2:0]  pwm_out
);

    // ****************************************
    // elaboration checks
    // ****************************************
    localparam longint HF_DIV =
        longint'(CLK_HZ) / (longint'(`FPR_HF_HZ) * `FPR_DUTY_STEPS);
    localparam logic [31:0] SLOT_LAST = 32'(RAMP_SLOT_CYC - 1);

    // generate-time checks refuse a build the counters cannot serve
    if (CLK_HZ < 1_000_000 || CLK_HZ > 200_000_000) begin : g_clk_chk
        $error("fpr_top: CLK_HZ out of range");
    end
    if (RAMP_SLOT_CYC < 1) begin : g_slot_chk
        $error("fpr_top: RAMP_SLOT_CYC must be positive");
    end
    if (HF_DIV < 1) begin : g_hf_chk
        $error("fpr_top: clock too slow for high rate");
    end
    // slowest rate must fit the 24-bit step counter
    if (longint'(CLK_HZ) * 10 / (longint'(`FPR_RATE_F10_0)
        * `FPR_DUTY_STEPS) > longint'(24'hffffff)) begin : g_div_chk
        $error("fpr_top: step counter too narrow");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        fpr_pkg::fpr_span_rate_s [2:0] span_rate;
        fpr_pkg::fpr_ramp_ctl_s        ramp_ctl;
        fpr_pkg::fpr_auto_cfg_s  [2:0] auto_cfg;
        fpr_pkg::fpr_chan_s      [2:0] chan;
        logic [7:0]                    ramp_duty;
        logic [31:0]                   slot_cnt;
        logic [2:0]                    pwm;
        logic [31:0]                   rdata;
        logic                          ready;
        logic                          slverr;
    } fpr_state_s;

    fpr_state_s st_ff;
    fpr_state_s nxt_st;

    // ****************************************
    // functions
    // ****************************************
    // cycles per duty step for a rate code
    function automatic logic [23:0] rate_div(input logic [2:0] code,
                                             input logic       hi);
        longint f10;
        longint d;
        f10 = 0;
        d   = 0;
        case (code)
            3'h0: f10 = `FPR_RATE_F10_0;
            3'h1: f10 = `FPR_RATE_F10_1;
            3'h2: f10 = `FPR_RATE_F10_2;
            3'h3: f10 = `FPR_RATE_F10_3;
            3'h4: f10 = `FPR_RATE_F10_4;
            3'h5: f10 = `FPR_RATE_F10_5;
            3'h6: f10 = `FPR_RATE_F10_6;
            default: f10 = `FPR_RATE_F10_7;
        endcase
        d = (longint'(CLK_HZ) * 10) / (f10 * `FPR_DUTY_STEPS);
        if (hi) begin
            d = HF_DIV;
        end
        if (d < 1) begin
            d = 1;
        end
        rate_div = d[23:0];
    endfunction

    // 256 / span in deg c, rounded
    function automatic logic [7:0] span_recip(input logic [3:0] code);
        case (code)
            4'h0: span_recip = 8'h80;
            4'h1: span_recip = 8'h66;
            4'h2: span_recip = 8'h4d;
            4'h3: span_recip = 8'h40;
            4'h4: span_recip = 8'h33;
            4'h5: span_recip = 8'h26;
            4'h6: span_recip = 8'h20;
            4'h7: span_recip = 8'h1a;
            4'h8: span_recip = 8'h13;
            4'h9: span_recip = 8'h10;
            4'ha: span_recip = 8'h0d;
            4'hb: span_recip = 8'h0a;
            4'hc: span_recip = 8'h08;
            4'hd: span_recip = 8'h06;
            4'he: span_recip = 8'h05;
            default: span_recip = 8'h03;
        endcase
    endfunction

    // linear duty from minimum at start temp to full at start + span
    function automatic logic [7:0] auto_duty(
        input logic [7:0] temp,
        input logic [7:0] tstart,
        input logic [7:0] dmin,
        input logic [3:0] span);
        logic [7:0]  head;
        logic [7:0]  diff;
        logic [23:0] prod;
        head = 8'hff - dmin;
        diff = temp - tstart;
        prod = 24'(head) * 24'(diff) * 24'(span_recip(span));
        // at or below the start temperature the fan idles at its minimum
        if (temp <= tstart) begin
            auto_duty = dmin;
        end else if (prod[23:8] >= 16'(head)) begin
            auto_duty = 8'hff;
        end else begin
            auto_duty = dmin + prod[15:8];
        end
    endfunction

    // duty steps added per slot
    function automatic logic [7:0] ramp_step(input logic [2:0] code);
        case (code)
            3'h0: ramp_step = 8'h01;
            3'h1: ramp_step = 8'h02;
            3'h2: ramp_step = 8'h03;
            3'h3: ramp_step = 8'h04;
            3'h4: ramp_step = 8'h08;
            3'h5: ramp_step = 8'h0c;
            3'h6: ramp_step = 8'h18;
            default: ramp_step = 8'h30;
        endcase
    endfunction

    // reset image of the whole state; duty starts at min, so pwm
    // may show high on the first edge after reset
    function automatic fpr_state_s rst_state();
        fpr_state_s s;
        s = '0;
        for (int i = 0; i < 3; i++) begin
            s.span_rate[i] = `FPR_SPAN_RATE_RST;
            s.auto_cfg[i]  = `FPR_AUTO_CFG_RST;
        end
        s.ramp_ctl = `FPR_RAMP_CTL_RST;
        rst_state = s;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    // channel i follows a fixed temperature input: remote1, local, remote2
    logic [7:0] temp_sel [3];

    assign temp_sel[0] = temp_remote1;
    assign temp_sel[1] = temp_local;
    assign temp_sel[2] = temp_remote2;

    always_comb begin
        logic [9:0]  idx;
        logic        wr;
        logic        setup;
        logic [7:0]  target [3];
        logic [7:0]  duty   [3];
        logic [7:0]  stp;
        logic [23:0] div;
        idx   = paddr[11:2];
        setup = psel && !penable;
        // misaligned writes refused like reads, not folded onto the word
        wr    = psel && penable && pwrite && st_ff.ready
                && paddr[1:0] == 2'h0;
        stp   = ramp_step(st_ff.ramp_ctl.ramp_step_select);
        div   = 24'h000000;
        target = '{default: 8'h00};
        duty   = '{default: 8'h00};
        nxt_st = st_ff;

        // read data decoded at setup so it stands through the access cycle
        // apb answer, ready in the access cycle
        nxt_st.ready  = setup;
        nxt_st.slverr = 1'b0;
        nxt_st.rdata  = 32'h00000000;
        if (setup) begin
            if (paddr[1:0] != 2'h0) begin
                nxt_st.slverr = 1'b1;
            end else if (idx == `FPR_IDX_SPAN_RATE1) begin
                nxt_st.rdata = {24'h000000, st_ff.span_rate[0]};
            end else if (idx == `FPR_IDX_SPAN_RATE2) begin
                nxt_st.rdata = {24'h000000, st_ff.span_rate[1]};
            end else if (idx == `FPR_IDX_SPAN_RATE3) begin
                nxt_st.rdata = {24'h000000, st_ff.span_rate[2]};
            end else if (idx == `FPR_IDX_RAMP_CTL) begin
                nxt_st.rdata = {28'h0000000, st_ff.ramp_ctl[3:0]};
            end else if (idx == `FPR_IDX_AUTO_CFG1) begin
                nxt_st.rdata = {16'h0000, st_ff.auto_cfg[0]};
            end else if (idx == `FPR_IDX_AUTO_CFG2) begin
                nxt_st.rdata = {16'h0000, st_ff.auto_cfg[1]};
            end else if (idx == `FPR_IDX_AUTO_CFG3) begin
                nxt_st.rdata = {16'h0000, st_ff.auto_cfg[2]};
            end else if (idx == `FPR_IDX_DUTY_STAT) begin
                nxt_st.rdata = {8'h00, st_ff.ramp_duty,
                                st_ff.chan[2].phase, st_ff.chan[0].phase};
            end else begin
                nxt_st.slverr = 1'b1;
            end
        end

        // register writes, locked span/rate writes dropped silently
        if (wr && pstrb[0]) begin
            if (idx == `FPR_IDX_SPAN_RATE1 && !cfg_lock) begin
                nxt_st.span_rate[0] = pwdata[7:0];
            end else if (idx == `FPR_IDX_SPAN_RATE2 && !cfg_lock) begin
                nxt_st.span_rate[1] = pwdata[7:0];
            end else if (idx == `FPR_IDX_SPAN_RATE3 && !cfg_lock) begin
                nxt_st.span_rate[2] = pwdata[7:0];
            end else if (idx == `FPR_IDX_RAMP_CTL) begin
                nxt_st.ramp_ctl = {4'h0, pwdata[3:0]};
            end else if (idx == `FPR_IDX_AUTO_CFG1) begin
                nxt_st.auto_cfg[0].auto_start_temp = pwdata[7:0];
            end else if (idx == `FPR_IDX_AUTO_CFG2) begin
                nxt_st.auto_cfg[1].auto_start_temp = pwdata[7:0];
            end else if (idx == `FPR_IDX_AUTO_CFG3) begin
                nxt_st.auto_cfg[2].auto_start_temp = pwdata[7:0];
            end
        end
        if (wr && pstrb[1]) begin
            if (idx == `FPR_IDX_AUTO_CFG1) begin
                nxt_st.auto_cfg[0].min_duty = pwdata[15:8];
            end else if (idx == `FPR_IDX_AUTO_CFG2) begin
                nxt_st.auto_cfg[1].min_duty = pwdata[15:8];
            end else if (idx == `FPR_IDX_AUTO_CFG3) begin
                nxt_st.auto_cfg[2].min_duty = pwdata[15:8];
            end
        end

        // targets from the temperature slope
        for (int i = 0; i < 3; i++) begin
            target[i] = auto_duty(temp_sel[i],
                                  st_ff.auto_cfg[i].auto_start_temp,
                                  st_ff.auto_cfg[i].min_duty,
                                  st_ff.span_rate[i].temp_span);
            duty[i] = target[i];
        end

        // pwm1 ramp, one move per slot while ramp enable is one; with it zero duty goes straight to target
        if (st_ff.slot_cnt >= SLOT_LAST) begin
            nxt_st.slot_cnt = 32'h00000000;
            if (st_ff.ramp_duty < target[0]) begin
                if (target[0] - st_ff.ramp_duty <= stp) begin
                    nxt_st.ramp_duty = target[0];
                end else begin
                    nxt_st.ramp_duty = st_ff.ramp_duty + stp;
                end
            end else if (st_ff.ramp_duty > target[0]) begin
                if (st_ff.ramp_duty - target[0] <= stp) begin
                    nxt_st.ramp_duty = target[0];
                end else begin
                    nxt_st.ramp_duty = st_ff.ramp_duty - stp;
                end
            end
        end else begin
            nxt_st.slot_cnt = st_ff.slot_cnt + 32'h00000001;
        end
        if (st_ff.ramp_ctl.ramp_enable_ch1) begin
            duty[0] = st_ff.ramp_duty;
        end else begin
            nxt_st.ramp_duty = target[0];
            nxt_st.slot_cnt  = 32'h00000000;
        end

        // pwm generation; a rate change takes hold in the step already in progress
        for (int i = 0; i < 3; i++) begin
            div = rate_div(st_ff.span_rate[i].pwm_rate_select,
                           st_ff.span_rate[i].high_rate_select);
            if (st_ff.chan[i].step_cnt >= div - 24'h000001) begin
                nxt_st.chan[i].step_cnt = 24'h000000;
                nxt_st.chan[i].phase    = st_ff.chan[i].phase + 8'h01;
            end else begin
                nxt_st.chan[i].step_cnt =
                    st_ff.chan[i].step_cnt + 24'h000001;
            end
            nxt_st.pwm[i] = (duty[i] == 8'hff) ||
                            (st_ff.chan[i].phase < duty[i]);
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_ff <= rst_state();
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata  = st_ff.rdata;
    assign pready  = st_ff.ready;
    assign pslverr = st_ff.slverr;
    assign pwm_out = st_ff.pwm;

endmodule

`default_nettype wire

// ### verif/fpr_checker.sv
// Purpose: port-level checks of the fan pwm span/rate block
// Assumes: single clock, synchronous active-high reset
// Notes:   a flag marks the first span/rate write
`include "fpr_map.svh"
`default_nettype none

module fpr_checker (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cfg_lock
);
    // ****
    // helpers
    // ****
    logic [9:0] idx;
    logic       acc;
    logic       sr_hit;
    logic       wr_seen_ff;

    assign idx    = paddr[11:2];
    assign acc    = psel && penable && pready;
    assign sr_hit = idx >= `FPR_IDX_SPAN_RATE1 && idx <= `FPR_IDX_SPAN_RATE3;

    // reset value is provable only until the first write
    always_ff @(posedge ref_clk) begin
        if (sys_rst)
            wr_seen_ff <= 1'b0;
        else if (acc && pwrite && sr_hit)
            wr_seen_ff <= 1'b1;
    end

    // ****
    // assertions
    // ****
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unmapped_refused: assert property (acc && (idx < `FPR_IDX_SPAN_RATE1
        || idx > `FPR_IDX_DUTY_STAT) |-> pslverr)
        else $error("unmapped access not refused");
    a_misaligned_refused: assert property (
        acc && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    a_span_rate_ok: assert property (
        acc && sr_hit && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("span/rate access refused");
    a_locked_write_silent: assert property (
        psel && !penable && pwrite && cfg_lock && sr_hit
        && paddr[1:0] == 2'b00 |=> pready && !pslverr)
        else $error("locked write not silent");
    a_reset_value_read: assert property (
        acc && !pwrite && sr_hit && !wr_seen_ff && paddr[1:0] == 2'b00
        |-> prdata[7:0] == `FPR_SPAN_RATE_RST)
        else $error("span/rate read not at reset value");

    c_locked_write: cover property (acc && pwrite && cfg_lock && sr_hit);
    c_refused: cover property (acc && pslverr);
    c_status_read: cover property (acc && !pwrite
        && idx == `FPR_IDX_DUTY_STAT);
endmodule

bind fpr_top fpr_checker u_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg_lock(cfg_lock)
);

`default_nettype wire

// ### verif/fpr_fan_model.sv
// Purpose: fans on the three pwm outputs
// Assumes: fans are plain loads, only drive pulses matter
// Notes:   counts rising drive edges per fan until cleared
`default_nettype none

module fpr_fan_model (
    input  wire logic             ref_clk,
    input  wire logic             clear,
    input  wire logic [2:0]       pwm_in,
    output logic      [2:0][15:0] rise_cnt
);
    logic [2:0] last_ff;

    always_ff @(posedge ref_clk) begin
        last_ff <= pwm_in;
        for (int i = 0; i < 3; i++) begin
            if (clear)
                rise_cnt[i] <= 16'h0000;
            else if (pwm_in[i] && !last_ff[i])
                rise_cnt[i] <= rise_cnt[i] + 16'h0001;
        end
    end
endmodule

`default_nettype wire

// ### verif/test_fan_pwm_rate_span_ramp.sv
// Purpose: directed test of the fan pwm span/rate/ramp block
// Assumes: apb master in the bench, fans counted by a model
// Notes:   low CLK_HZ makes the high-rate period 256 cycles
`include "fpr_map.svh"
`default_nettype none

module test_fan_pwm_rate_span_ramp;
    timeunit 1ns;
    timeprecision 1ps;

    logic             ref_clk;
    logic             sys_rst;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [11:0]      paddr;
    logic [31:0]      pwdata;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             cfg_lock;
    logic             clear;
    logic [7:0]       temp_remote1;
    logic [7:0]       temp_local;
    logic [7:0]       temp_remote2;
    logic [2:0]       pwm_out;
    logic [2:0][15:0] rise_cnt;
    logic [31:0]      rv;
    logic             re;
    logic [7:0]       d0;
    logic [1:0]       alo = 2'b00;
    logic [7:0]       val [3] = '{8'hc5, 8'hc8, 8'h17};
    int               failures = 0;
    int               cmp_count = 0;

    fpr_top #(.CLK_HZ(6_400_000), .RAMP_SLOT_CYC(20)) DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfg_lock(cfg_lock),
        .temp_remote1(temp_remote1), .temp_local(temp_local),
        .temp_remote2(temp_remote2), .pwm_out(pwm_out)
    );
    fpr_fan_model fans (
        .ref_clk(ref_clk), .clear(clear), .pwm_in(pwm_out),
        .rise_cnt(rise_cnt)
    );

    // ****
    // shared tasks
    // ****
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // holds the request until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [9:0] idx,
                       input logic [7:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, alo};
        pwdata  <= {24'h000000, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rv = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_reset_values;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, `FPR_IDX_SPAN_RATE1 + 10'(i), 8'h00);
            check("reset_value", rv[7:0], 8'hcc);
        end
        apb(1'b0, 10'h000, 8'h00);
        check("unmapped_err", {7'h00, re}, 8'h01);
        alo = 2'b01;
        apb(1'b0, `FPR_IDX_SPAN_RATE1, 8'h00);
        check("misaligned_err", {7'h00, re}, 8'h01);
        apb(1'b1, `FPR_IDX_SPAN_RATE1, 8'h00);
        alo = 2'b00;
        apb(1'b0, `FPR_IDX_SPAN_RATE1, 8'h00);
        check("misaligned_wr", rv[7:0], `FPR_SPAN_RATE_RST);
    endtask

    // unlocked: values land; locked: zero writes must leave them
    task automatic t_span(input logic lock);
        cfg_lock <= lock;
        for (int i = 0; i < 3; i++)
            apb(1'b1, `FPR_IDX_SPAN_RATE1 + 10'(i), lock ? 8'h00 : val[i]);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, `FPR_IDX_SPAN_RATE1 + 10'(i), 8'h00);
            check("span_rate", rv[7:0], val[i]);
        end
        cfg_lock <= 1'b0;
    endtask

    // only fan 2 has the high-rate bit set
    task automatic t_high_rate;
        clear <= 1'b1;
        @(posedge ref_clk);
        clear <= 1'b0;
        repeat (2560) @(negedge ref_clk);
        check("fan1_slow", 8'(rise_cnt[0] <= 16'h0001), 8'h01);
        check("fan2_fast", 8'(rise_cnt[1] >= 16'h0008), 8'h01);
        check("fan3_slow", 8'(rise_cnt[2] <= 16'h0001), 8'h01);
        @(posedge ref_clk);
    endtask

    task automatic t_auto_curve;
        logic [7:0] tt [3] = '{8'h00, 8'h10, 8'h28};
        logic [7:0] lo [3] = '{8'h40, 8'h9e, 8'hff};
        logic [7:0] hi [3] = '{8'h40, 8'ha1, 8'hff};
        logic       ok;
        for (int i = 0; i < 3; i++) begin
            temp_remote1 <= tt[i];
            repeat (4) @(posedge ref_clk);
            apb(1'b0, `FPR_IDX_DUTY_STAT, 8'h00);
            ok = rv[23:16] >= lo[i] && rv[23:16] <= hi[i];
            check("auto_duty", {7'h00, ok}, 8'h01);
        end
    endtask

    // ~204 cycles between reads at 20-cycle slots: 10 or 11 slots
    task automatic t_ramp;
        logic ok;
        for (int c = 0; c < 3; c++) begin
            temp_remote1 <= 8'h00;
            repeat (4) @(posedge ref_clk);
            apb(1'b1, `FPR_IDX_RAMP_CTL, 8'h08 | 8'(c));
            temp_remote1 <= 8'hff;
            apb(1'b0, `FPR_IDX_DUTY_STAT, 8'h00);
            d0 = rv[23:16];
            repeat (200) @(posedge ref_clk);
            apb(1'b0, `FPR_IDX_DUTY_STAT, 8'h00);
            ok = rv[23:16] - d0 >= 8'(10 * c + 10)
                 && rv[23:16] - d0 <= 8'(11 * c + 11);
            check("ramp_held", {7'h00, d0 < 8'h48}, 8'h01);
            check("ramp_step", {7'h00, ok}, 8'h01);
            apb(1'b1, `FPR_IDX_RAMP_CTL, 8'h00);
            apb(1'b0, `FPR_IDX_DUTY_STAT, 8'h00);
            check("ramp_off", rv[23:16], 8'hff);
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        sys_rst      <= 1'b1;
        psel         <= 1'b0;
        penable      <= 1'b0;
        pwrite       <= 1'b0;
        paddr        <= 12'h000;
        pwdata       <= 32'h00000000;
        cfg_lock     <= 1'b0;
        clear        <= 1'b0;
        temp_remote1 <= 8'h00;
        temp_local   <= 8'h00;
        temp_remote2 <= 8'h00;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        t_reset_values();
        t_span(1'b0);
        t_high_rate();
        t_auto_curve();
        t_ramp();
        t_span(1'b1);
        give_verdict();
    end

    // run needs about 3.3k cycles, so 20k means a hang
    initial begin
        #200_000;
        failures++;
        give_verdict();
    end
endmodule

`default_nettype wire
